// File: rtl/tsa_pkg.sv
// ****************************************************************
// Constants of the timeslot access block
// ****************************************************************
package tsa_pkg;

    localparam int NUM_REGS = 4;
    localparam int DATA_W   = 8;

    // Register byte addresses
    localparam logic [7:0] OFF_DATA_BASE = 8'h00;
    localparam logic [7:0] OFF_SEL_BASE  = 8'h10;
    localparam logic [7:0] OFF_CTRL1     = 8'h20;
    localparam logic [7:0] OFF_CTRL2     = 8'h24;
    localparam logic [7:0] OFF_STATUS    = 8'h28;
    localparam logic [7:0] OFF_MASK      = 8'h2c;
    localparam logic [7:0] OFF_ACK       = 8'h30;
    localparam logic [3:0] GROUP_DATA    = 4'h0;
    localparam logic [3:0] GROUP_SEL     = 4'h1;

    // Field positions of slot_port_select
    localparam int SEL_DPS     = 7;
    localparam int SEL_SLOT_HI = 4;
    localparam int SEL_SLOT_LO = 0;

    // Field positions of pair_control_reg
    localparam int CTRL_OUT1 = 0;
    localparam int CTRL_OUT0 = 1;
    localparam int CTRL_IN1  = 2;
    localparam int CTRL_IN0  = 3;
    localparam int CTRL_ARB  = 5;

    // Status register layout: transfer flags low, overflow flags high
    localparam int STAT_OV_LO = 4;

    // Reset values
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] SEL_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] STAT_RST = 8'h00;

    // Frame timing
    localparam int         DCL_PER_BIT    = 2;
    localparam logic [4:0] ARB_SLOT       = 5'h0b;
    localparam logic [2:0] SLOT_LAST_BIT  = 3'h7;
    localparam logic [2:0] SLOT_FIRST_BIT = 3'h0;
    localparam logic [7:0] DELAY_DPS0     = 8'h02;
    localparam logic [7:0] DELAY_DPS1     = 8'h01;
    localparam logic [7:0] BIT_COUNT_RST  = 8'h00;

    // Index of a timeslot data or selector register from its address
    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        reg_index = addr[3:2];
    endfunction : reg_index

endpackage : tsa_pkg

// File: rtl/tsa_link_timer.sv
`timescale 1ns/100ps
// ****************************************************************
// Link sampler and frame bit counter
// ****************************************************************
module tsa_link_timer
    import tsa_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       frame_data_clock,
    input  wire logic       frame_sync,
    input  wire logic       upstream_line_in,
    input  wire logic       downstream_line_in,
    output logic            bit_tick,
    output logic [7:0]      bit_count,
    output logic            up_bit,
    output logic            down_bit
);

    logic [3:0] meta;
    logic [3:0] sync;
    logic       prev_dcl;
    logic       prev_fs;
    logic       phase;

    wire dcl_rise = sync[0] & ~prev_dcl;
    wire fs_rise  = sync[1] & ~prev_fs;

    // Two-stage synchronisers for all link pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 4'h0;
            sync <= 4'h0;
        end else begin
            meta <= {downstream_line_in, upstream_line_in, frame_sync, frame_data_clock};
            sync <= meta;
        end
    end

    // Edge history of the synchronised clock and sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_dcl <= 1'b0;
            prev_fs  <= 1'b0;
        end else begin
            prev_dcl <= sync[0];
            prev_fs  <= sync[1];
        end
    end

    // bit clock halves
    // One bit clock is DCL_PER_BIT frame data clock rises
    assign bit_tick = dcl_rise & phase;
    assign up_bit   = sync[2];
    assign down_bit = sync[3];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase     <= 1'b0;
            bit_count <= BIT_COUNT_RST;
        end else if (fs_rise) begin
            phase     <= 1'b0;
            bit_count <= BIT_COUNT_RST;
        end else if (dcl_rise) begin
            phase <= ~phase;
            if (phase) begin
                bit_count <= bit_count + 8'h01;
            end
        end
    end

endmodule : tsa_link_timer

// File: rtl/tsa_slot_channel.sv
`timescale 1ns/100ps
// ****************************************************************
// One timeslot data register with its slot timing
// ****************************************************************
module tsa_slot_channel
    import tsa_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       bit_tick,
    input  wire logic [7:0] bit_count,
    input  wire logic [7:0] sel,
    input  wire logic       arb_mon,
    input  wire logic       in_en,
    input  wire logic       out_en,
    input  wire logic       up_bit,
    input  wire logic       down_bit,
    input  wire logic       sw_wr,
    input  wire logic [7:0] sw_data,
    input  wire logic       ack,
    output logic [7:0]      data,
    output logic            drive_bit,
    output logic            drive_en,
    output logic            drive_down,
    output logic            fire,
    output logic            miss
);

    logic [7:0] shift;
    logic [7:0] pend;
    logic       pend_valid;
    logic       pending;

    // Slot, port and timing decode
    wire [4:0] slot     = sel[SEL_SLOT_HI:SEL_SLOT_LO];
    wire       port_select_bit      = sel[SEL_DPS];
    wire [7:0] delay    = port_select_bit ? DELAY_DPS1 : DELAY_DPS0;
    wire [7:0] fire_pos = {slot, SLOT_LAST_BIT} + delay;
    wire [7:0] dead_pos = {slot, SLOT_FIRST_BIT} - delay;
    wire [7:0] next_bit = bit_count + 8'h01;
    wire [4:0] in_slot  = arb_mon ? ARB_SLOT : slot;
    wire       in_bit   = port_select_bit ? down_bit : up_bit;
    wire       in_hit   = bit_tick & (bit_count[7:3] == in_slot);
    wire       in_last  = in_hit & (bit_count[2:0] == SLOT_LAST_BIT);

    assign drive_down = ~port_select_bit;
    assign drive_en   = out_en & (next_bit[7:3] == slot);
    assign drive_bit  = data[SLOT_LAST_BIT - next_bit[2:0]];
    assign fire = in_en & bit_tick & (bit_count == fire_pos);
    assign miss = bit_tick & (bit_count == dead_pos) & pending;

    // Unacknowledged transfer; a new one wins over an acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
        end else if (fire) begin
            pending <= 1'b1;
        end else if (ack) begin
            pending <= 1'b0;
        end
    end

    // Serial capture of the selected slot, MSB first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift <= DATA_RST;
        end else if (in_hit) begin
            shift <= {shift[6:0], in_bit};
        end
    end

    // Software writes are parked until the output is enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend       <= DATA_RST;
            pend_valid <= 1'b0;
        end else if (sw_wr) begin
            pend       <= sw_data;
            pend_valid <= 1'b1;
        end else if (out_en) begin
            pend_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data <= DATA_RST;
        end else if (in_last && in_en) begin
            data <= {shift[6:0], in_bit};
        end else if (out_en && pend_valid) begin
            data <= pend;
        end
    end

endmodule : tsa_slot_channel

// File: rtl/tsa_timeslot_access.sv
`timescale 1ns/100ps
// Operation
// - Arbitration monitor bit makes register 0 of a pair capture slot 11.
// - Slot 11 and slot 3 can be captured together on both lines.
// - Four transfer and four overflow flags share one status register.
// - Transfer flag fires two bits after slot, one bit when port bit set.
// - One bit clock spans two frame data clocks.
// - Overflow follows its own transfer only if enabled and unacknowledged.
// - Masked transfer lets its overflow follow any other enabled missed one.
// - No transfer enabled means no interrupt at all.
// - No overflow when every stimulating transfer was acknowledged.
// - Transfer flag needs the register input enabled.
// - Overflow flag needs the register output enabled.
// - With both directions off, reads return the previous value.
// - Slot selector picks one slot from 0 to 31.
// - Disabled input keeps and drives the held value.
module tsa_timeslot_access
    import tsa_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        frame_data_clock,
    input  wire logic        frame_sync,
    input  wire logic        upstream_line_in,
    input  wire logic        downstream_line_in,
    output logic             upstream_line_out,
    output logic             upstream_line_oe,
    output logic             downstream_line_out,
    output logic             downstream_line_oe,
    output logic             sync_irq
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] slot_port_select [NUM_REGS];
    logic [7:0] pair_control_reg [2];
    logic [7:0] irq_status;
    logic [7:0] transfer_irq_mask_reg;

    // Link timing
    logic       bit_tick;
    logic [7:0] bit_count;
    logic       up_bit;
    logic       down_bit;

    // Per register channel signals
    logic [7:0]          timeslot_data_reg [NUM_REGS];
    logic [NUM_REGS-1:0] in_en;
    logic [NUM_REGS-1:0] out_en;
    logic [NUM_REGS-1:0] arb_mon;
    logic [NUM_REGS-1:0] data_wr;
    logic [NUM_REGS-1:0] drive_bit;
    logic [NUM_REGS-1:0] drive_en;
    logic [NUM_REGS-1:0] drive_down;
    logic [NUM_REGS-1:0] fire;
    logic [NUM_REGS-1:0] miss;
    logic [NUM_REGS-1:0] transfer_ack_bit;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire        access   = psel & penable;
    wire        wr_en    = access & pwrite;
    wire        rd_en    = access & ~pwrite;
    wire [1:0]  idx      = reg_index(paddr);
    wire        hit_data = (paddr[7:4] == GROUP_DATA);
    wire        hit_sel  = (paddr[7:4] == GROUP_SEL);
    wire        hit_c1   = (paddr[7:2] == OFF_CTRL1[7:2]);
    wire        hit_c2   = (paddr[7:2] == OFF_CTRL2[7:2]);
    wire        hit_stat = (paddr[7:2] == OFF_STATUS[7:2]);
    wire        hit_mask = (paddr[7:2] == OFF_MASK[7:2]);
    wire        hit_ack  = (paddr[7:2] == OFF_ACK[7:2]);
    wire        mapped   = hit_data | hit_sel | hit_c1 | hit_c2
                         | hit_stat | hit_mask | hit_ack;
    wire [7:0]  wbyte    = pwdata[7:0];

    // Zero wait state slave, error on unmapped addresses
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // Read data selection; acknowledge register reads as zero
    wire [7:0] rd_byte =
        hit_data ? timeslot_data_reg[idx] :
        hit_sel  ? slot_port_select[idx]  :
        hit_c1   ? pair_control_reg[0]    :
        hit_c2   ? pair_control_reg[1]    :
        hit_stat ? irq_status             :
        hit_mask ? transfer_irq_mask_reg  : 8'h00;
    assign prdata = {24'h000000, rd_byte};

    // ****************************************************************
    // Configuration registers
    // ****************************************************************

    // Slot and port selectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                slot_port_select[i] <= SEL_RST;
            end
        end else if (wr_en && hit_sel) begin
            slot_port_select[idx] <= wbyte;
        end
    end

    // Pair control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_control_reg[0] <= CTRL_RST;
            pair_control_reg[1] <= CTRL_RST;
        end else if (wr_en && hit_c1) begin
            pair_control_reg[0] <= wbyte;
        end else if (wr_en && hit_c2) begin
            pair_control_reg[1] <= wbyte;
        end
    end

    // Interrupt mask, set bit masks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_irq_mask_reg <= MASK_RST;
        end else if (wr_en && hit_mask) begin
            transfer_irq_mask_reg <= wbyte;
        end
    end

    assign transfer_ack_bit = (wr_en && hit_ack) ? wbyte[NUM_REGS-1:0] : '0;

    // ****************************************************************
    // Link timing and the four channels
    // ****************************************************************
    tsa_link_timer u_timer (
        .pclk               (pclk),
        .presetn            (presetn),
        .frame_data_clock   (frame_data_clock),
        .frame_sync         (frame_sync),
        .upstream_line_in   (upstream_line_in),
        .downstream_line_in (downstream_line_in),
        .bit_tick           (bit_tick),
        .bit_count          (bit_count),
        .up_bit             (up_bit),
        .down_bit           (down_bit)
    );

    // Register y of pair x sits at index 2*x+y
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_chan
            localparam int P = g / 2;
            localparam int Y = g % 2;
            assign in_en[g]   = pair_control_reg[P][(Y == 0) ? CTRL_IN0 : CTRL_IN1];
            assign out_en[g]  = pair_control_reg[P][(Y == 0) ? CTRL_OUT0 : CTRL_OUT1];
            // register 1 keeps its own slot
            assign arb_mon[g] = (Y == 0) && pair_control_reg[P][CTRL_ARB];
            assign data_wr[g] = wr_en && hit_data && (idx == 2'(g));

            tsa_slot_channel u_chan (
                .pclk       (pclk),
                .presetn    (presetn),
                .bit_tick   (bit_tick),
                .bit_count  (bit_count),
                .sel        (slot_port_select[g]),
                .arb_mon    (arb_mon[g]),
                .in_en      (in_en[g]),
                .out_en     (out_en[g]),
                .up_bit     (up_bit),
                .down_bit   (down_bit),
                .sw_wr      (data_wr[g]),
                .sw_data    (wbyte),
                .ack        (transfer_ack_bit[g]),
                .data       (timeslot_data_reg[g]),
                .drive_bit  (drive_bit[g]),
                .drive_en   (drive_en[g]),
                .drive_down (drive_down[g]),
                .fire       (fire[g]),
                .miss       (miss[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Synchronous transfer and overflow interrupts
    // ****************************************************************

    // Enables are the inverted mask bits; overflow ones also need out_en
    wire [NUM_REGS-1:0] sti_en   = ~transfer_irq_mask_reg[NUM_REGS-1:0];
    wire [NUM_REGS-1:0] sync_overflow_irq_en  = ~transfer_irq_mask_reg[7:STAT_OV_LO] & out_en;
    wire [NUM_REGS-1:0] own_miss = miss & sti_en;
    wire                any_miss = |own_miss;

    logic [NUM_REGS-1:0] sync_overflow_irq_set;
    always_comb begin
        for (int k = 0; k < NUM_REGS; k++) begin
            sync_overflow_irq_set[k] = sync_overflow_irq_en[k] & (sti_en[k] ? own_miss[k] : any_miss);
        end
    end

    wire [7:0] stat_set = {sync_overflow_irq_set, fire};
    wire [7:0] stat_clr = (rd_en && hit_stat) ? 8'hff : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= STAT_RST;
        end else begin
            irq_status <= (irq_status & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_irq <= 1'b0;
        end else begin
            sync_irq <= |(irq_status & ~transfer_irq_mask_reg);
        end
    end

    // ****************************************************************
    // Line drivers
    // ****************************************************************
    wire up_drv   = |(drive_en & ~drive_down);
    wire down_drv = |(drive_en & drive_down);
    wire up_val   = |(drive_en & ~drive_down & drive_bit);
    wire down_val = |(drive_en & drive_down & drive_bit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upstream_line_out   <= 1'b0;
            upstream_line_oe    <= 1'b0;
            downstream_line_out <= 1'b0;
            downstream_line_oe  <= 1'b0;
        end else if (bit_tick) begin
            upstream_line_out   <= up_val;
            upstream_line_oe    <= up_drv;
            downstream_line_out <= down_val;
            downstream_line_oe  <= down_drv;
        end
    end

endmodule : tsa_timeslot_access

// File: dv/tsa_link_partner.sv
`timescale 1ns/100ps
// ****
// Serial frame source on both lines
// ****
module tsa_link_partner
(
    output logic frame_data_clock,
    output logic frame_sync,
    output logic upstream_line_in,
    output logic downstream_line_in
);
    int         half;
    int         k;
    logic [7:0] ub;
    logic [7:0] db;

    // Free running data clock and idle lines at start
    initial begin
        half = 511;
        frame_data_clock = 1'b0;
        frame_sync = 1'b0;
        upstream_line_in = 1'b1;
        downstream_line_in = 1'b1;
    end
    always #62.5 frame_data_clock = ~frame_data_clock;

    // no loopback: driven outputs never feed back into the inputs
    // Bits change on a falling edge and stay for two data clocks
    always @(negedge frame_data_clock) begin
        half = (half + 1) % 512;
        k = half / 2;
        ub = 8'((k / 8) * 37 + 8'h13);
        db = 8'((k / 8) * 37 + 8'h5c);
        frame_sync = (k == 0);
        upstream_line_in = ub[7 - k % 8];
        downstream_line_in = db[7 - k % 8];
    end
endmodule : tsa_link_partner

// File: dv/tsa_checker.sv
`timescale 1ns/100ps
module tsa_checker
    import tsa_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sync_irq
);
    // ****
    // Access decode and mask shadow
    // ****
    logic [7:0] mask_sh;
    wire        acc    = psel && penable;
    wire        rd     = acc && !pwrite;
    wire        mapped = paddr[7:2] <= 6'd12;

    // Shadow of the mask written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_sh <= MASK_RST;
        end else if (acc && pwrite && paddr[7:2] == OFF_MASK[7:2]) begin
            mask_sh <= pwdata[7:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****
    // Bus and interrupt properties
    // ****
    a_ready_high: assert property (psel |-> pready) else $error("wait state");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error");
    a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("false error");
    a_err_data_zero: assert property (rd && !mapped |-> prdata == 32'h0) else $error("err data");
    a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper bits");
    a_ack_reads_zero: assert property (rd && paddr == OFF_ACK |-> prdata == 32'h0)
        else $error("ack read");
    a_mask_readback: assert property (rd && paddr == OFF_MASK |-> prdata[7:0] == mask_sh)
        else $error("mask read");
    a_irq_all_masked: assert property (mask_sh == 8'hff && $past(mask_sh) == 8'hff
        |-> !sync_irq) else $error("irq while masked");
    a_irq_rise_cause: assert property ($rose(sync_irq) |-> $past(mask_sh, 1) != 8'hff)
        else $error("irq rise masked");

    c_write: cover property (acc && pwrite);
    c_irq: cover property ($rose(sync_irq));
    c_overflow: cover property (rd && paddr == OFF_STATUS && prdata[7:4] != 4'h0);
endmodule : tsa_checker

bind tsa_timeslot_access tsa_checker u_chk (.*);

// File: dv/tsa_timeslot_access_tb_top.sv
`timescale 1ns/100ps
module tsa_timeslot_access_tb_top
    import tsa_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, sync_irq, frame_data_clock, frame_sync;
    logic        upstream_line_in, downstream_line_in, upstream_line_out;
    logic        upstream_line_oe, downstream_line_out, downstream_line_oe;
    logic [31:0] seed = 32'd44128;
    logic [31:0] r;
    logic        e;
    logic [7:0]  mdl [0:12];
    int          failures = 0;
    int          compares = 0;

    tsa_timeslot_access uut (.*);
    tsa_link_partner u_link (.*);

    // Bench clock
    always #5 pclk = ~pclk;

    // ****
    // Helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    function automatic logic [7:0] ub(input int s, input int dn);
        return 8'(s * 37 + (dn != 0 ? 8'h5c : 8'h13));
    endfunction : ub

    task automatic final_report;
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rv, output logic ev);
        int   n;
        logic rdy;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is read while settled, ahead of the edge that takes it
        do begin
            @(negedge pclk);
            rv  = prdata;
            ev  = pslverr;
            rdy = pready;
            @(posedge pclk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            final_report;
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d, r, e);
        if (a[7:2] inside {[4:9], 11}) mdl[a[7:2]] = d;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic ex);
        apb(1'b0, a, 8'h00, r, e);
        chk("prdata", r, {24'h0, x});
        chk("pslverr", {31'h0, e}, {31'h0, ex});
    endtask : rd

    // Bounded wait for a level on the irq (0) or frame start (1)
    task automatic wait_for(input int which, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((which != 0 ? frame_sync : sync_irq) !== v && n < 14000);
        if (n >= 14000) begin
            failures++;
            final_report;
        end
    endtask : wait_for

    task automatic wait_irq;
        wait_for(0, 1'b0);
        wait_for(0, 1'b1);
    endtask : wait_irq

    // ****
    // Main sequence
    // ****
    initial begin
        for (int i = 0; i < 13; i++) mdl[i] = (i < 4 || i == 11) ? 8'hff : 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++) rd(8'(i * 4), mdl[i], 1'b0);
        wr(8'h34, 8'h55);
        rd(8'h34, 8'h00, 1'b1);
        rd(8'hfc, 8'h00, 1'b1);
        for (int i = 4; i < 8; i++) begin
            seed = xs(seed);
            wr(8'(i * 4), seed[7:0] & 8'h9f);
            rd(8'(i * 4), mdl[i], 1'b0);
        end
        seed = xs(seed);
        wr(OFF_CTRL1, 8'h00);
        wr(OFF_DATA_BASE, {1'b0, seed[6:0]});
        rd(OFF_DATA_BASE, 8'hff, 1'b0);
        wr(OFF_CTRL1, 8'h02);
        rd(OFF_DATA_BASE, {1'b0, seed[6:0]}, 1'b0);
        wait_for(1, 1'b0);
        wait_for(1, 1'b1);
        rd(OFF_DATA_BASE, {1'b0, seed[6:0]}, 1'b0);
        wr(OFF_SEL_BASE, 8'h05);
        wr(OFF_CTRL1, 8'h0a);
        wr(OFF_MASK, 8'hfe);
        apb(1'b0, OFF_STATUS, 8'h00, r, e);
        wait_irq;
        rd(OFF_STATUS, 8'h01, 1'b0);
        rd(OFF_DATA_BASE, ub(5, 0), 1'b0);
        wr(OFF_ACK, 8'h01);
        wr(OFF_MASK, 8'hee);
        wait_irq;
        rd(OFF_STATUS, 8'h01, 1'b0);
        wait_irq;
        rd(OFF_STATUS, 8'h10, 1'b0);
        wait_irq;
        rd(OFF_STATUS, 8'h01, 1'b0);
        wr(OFF_CTRL1, 8'h0b);
        wr(OFF_MASK, 8'hde);
        wait_irq;
        rd(OFF_STATUS, 8'h20, 1'b0);
        wr(OFF_CTRL1, 8'h03);
        wr(OFF_MASK, 8'h00);
        wr(OFF_ACK, 8'h0f);
        apb(1'b0, OFF_STATUS, 8'h00, r, e);
        repeat (2) begin
            wait_for(1, 1'b0);
            wait_for(1, 1'b1);
        end
        rd(OFF_STATUS, 8'h00, 1'b0);
        chk("sync_irq", {31'h0, sync_irq}, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wr(OFF_SEL_BASE, k != 0 ? 8'h88 : 8'h08);
            wr(OFF_SEL_BASE + 8'h04, k != 0 ? 8'h83 : 8'h03);
            wr(OFF_CTRL1, 8'h2f);
            repeat (2) begin
                wait_for(1, 1'b0);
                wait_for(1, 1'b1);
            end
            rd(OFF_DATA_BASE, ub(11, k), 1'b0);
            rd(OFF_DATA_BASE + 8'h04, ub(3, k), 1'b0);
        end
        final_report;
    end
endmodule : tsa_timeslot_access_tb_top
